/* File: pkg/asfp_pkg.sv */
// How it works
// - Buffer holds 32 sets, each a 14-bit X, Y and Z value.
// - Outside bypass, output registers 28h-2Dh show the oldest buffered set.
// - Auto-increment burst reads wrap from 0x2D back to 0x28.
// - Threshold flag is 1 when unread count is at or above threshold.
// - A zero threshold holds the threshold flag at 0.
// - Overwriting an unread slot sets the overrun flag.
// - Six-bit level field gives unread sets, 0 empty, 32 full.
// - Bypass collects nothing; output registers hold only the newest sample.
// - Writing bypass clears the buffer; host restarts with bypass then 001.
// - Mode 001 stores sets until 32 unread, then stops.
// - Mode 110 keeps storing; when full the oldest is replaced, overrun set.
// - Threshold flag drives pin one and pin two through their route bits.
// - Mode 011 runs continuous until trigger, then stops when full.
// - Trigger is any tap, double tap, wake-up, free-fall or 6D event routed to pin one.
// - Mode 100 bypasses until trigger; the next set is stored first.
// - Bandwidth field and path bit choose direct, second low-pass or high-pass.
// - Direct and low-pass paths subtract weighted user offset when offset-to-output is set.
// - Reference-mode bit puts the high-pass filter in reference mode.
package asfp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_RATE_MODE = 7'h20;
  localparam logic [6:0] ADDR_IF_CTRL = 7'h21;
  localparam logic [6:0] ADDR_PIN1_ROUTE = 7'h23;
  localparam logic [6:0] ADDR_PIN2_ROUTE = 7'h24;
  localparam logic [6:0] ADDR_FILTER_CTRL = 7'h25;
  localparam logic [6:0] ADDR_OUT_FIRST = 7'h28;
  localparam logic [6:0] ADDR_OUT_LAST = 7'h2D;
  localparam logic [6:0] ADDR_BUF_CTRL = 7'h2E;
  localparam logic [6:0] ADDR_BUF_LEVEL = 7'h2F;
  localparam logic [6:0] ADDR_X_OFFSET = 7'h3C;
  localparam logic [6:0] ADDR_Y_OFFSET = 7'h3D;
  localparam logic [6:0] ADDR_Z_OFFSET = 7'h3E;
  localparam logic [6:0] ADDR_OFS_CTRL = 7'h3F;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUTO_INC_BIT = 2;
  localparam int THRESH_ROUTE_BIT = 1;
  localparam int PATH_SELECT_BIT = 3;
  localparam int BW_LSB = 6;
  localparam int OFS_TO_OUT_BIT = 4;
  localparam int OFS_WEIGHT_BIT = 2;
  localparam int HP_REF_BIT = 1;
  localparam int MODE_LSB = 5;
  localparam int FLAG_THRESH_BIT = 7;
  localparam int FLAG_OVR_BIT = 6;
  localparam int TRIG_ROUTE_LSB = 3;
  // ----------------------------------------------------------------
  // Sizes, reset values and scaling
  // ----------------------------------------------------------------
  localparam int DEPTH = 32;
  localparam int SAMPLE_W = 14;
  localparam int EVENT_W = 5;
  localparam logic [5:0] FULL_LEVEL = 6'h20;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IF_CTRL_RESET = 8'h04;
  localparam int OFS_SHIFT_LIGHT = 1;
  localparam int OFS_SHIFT_HEAVY = 4;
  typedef enum logic [2:0] {
    ASFP_BYPASS = 3'b000,
    ASFP_STOP_FULL = 3'b001,
    ASFP_CONT_TO_STOP = 3'b011,
    ASFP_BYPASS_TO_CONT = 3'b100,
    ASFP_CONTINUOUS = 3'b110
  } asfp_mode_t;
endpackage

/* File: design/asfp_core.sv */
`timescale 1ns/1ns
`default_nettype none
module asfp_core
(
  clk,
  reset,
  accStart,
  accAddr,
  accWrite,
  accWrData,
  accRead,
  accRdData,
  accRdValid,
  sampleValid,
  sampleX,
  sampleY,
  sampleZ,
  eventFlags,
  intPinOne,
  intPinTwo
);
  input wire logic clk;
  input wire logic reset;
  input wire logic accStart;
  input wire logic [6:0] accAddr;
  input wire logic accWrite;
  input wire logic [7:0] accWrData;
  input wire logic accRead;
  output logic [7:0] accRdData;
  output logic accRdValid;
  input wire logic sampleValid;
  input wire logic [asfp_pkg::SAMPLE_W-1:0] sampleX;
  input wire logic [asfp_pkg::SAMPLE_W-1:0] sampleY;
  input wire logic [asfp_pkg::SAMPLE_W-1:0] sampleZ;
  input wire logic [asfp_pkg::EVENT_W-1:0] eventFlags;
  output logic intPinOne;
  output logic intPinTwo;
  import asfp_pkg::*;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] rateModeReg;
  logic [7:0] ifCtrlReg;
  logic [7:0] pin1RouteReg;
  logic [7:0] pin2RouteReg;
  logic [7:0] filterCtrlReg;
  logic [7:0] bufCtrlReg;
  logic [7:0] offsetReg [3];
  logic [7:0] ofsCtrlReg;
  logic [6:0] ptrReg;
  logic [6:0] ptrNext;
  logic [6:0] curAddr;
  logic bufCtrlWr;
  logic bypassWr;

  assign curAddr = accStart ? accAddr : ptrReg;
  assign bufCtrlWr = accWrite && curAddr == ADDR_BUF_CTRL;
  assign bypassWr = bufCtrlWr && accWrData[MODE_LSB+:3] == ASFP_BYPASS;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rateModeReg <= REG_RESET;
      ifCtrlReg <= IF_CTRL_RESET;
      pin1RouteReg <= REG_RESET;
      pin2RouteReg <= REG_RESET;
      filterCtrlReg <= REG_RESET;
      bufCtrlReg <= REG_RESET;
      offsetReg[0] <= REG_RESET;
      offsetReg[1] <= REG_RESET;
      offsetReg[2] <= REG_RESET;
      ofsCtrlReg <= REG_RESET;
    end
    else if (accWrite)
      case (curAddr)
        ADDR_RATE_MODE: rateModeReg <= accWrData;
        ADDR_IF_CTRL: ifCtrlReg <= accWrData;
        ADDR_PIN1_ROUTE: pin1RouteReg <= accWrData;
        ADDR_PIN2_ROUTE: pin2RouteReg <= accWrData;
        ADDR_FILTER_CTRL: filterCtrlReg <= accWrData;
        ADDR_BUF_CTRL: bufCtrlReg <= accWrData;
        ADDR_X_OFFSET: offsetReg[0] <= accWrData;
        ADDR_Y_OFFSET: offsetReg[1] <= accWrData;
        ADDR_Z_OFFSET: offsetReg[2] <= accWrData;
        ADDR_OFS_CTRL: ofsCtrlReg <= accWrData;
        default: ;
      endcase
  end

  // ----------------------------------------------------------------
  // Access pointer with auto-increment and output-window wrap
  // ----------------------------------------------------------------
  always_comb
  begin
    ptrNext = curAddr;
    if ((accRead || accWrite) && ifCtrlReg[AUTO_INC_BIT])
    begin
      if (curAddr == ADDR_OUT_LAST)
        ptrNext = ADDR_OUT_FIRST;
      else
        ptrNext = curAddr + 7'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ptrReg <= ADDR_OUT_FIRST;
    else
      ptrReg <= ptrNext;
  end

  // ----------------------------------------------------------------
  // Filter path
  // ----------------------------------------------------------------
  logic signed [15:0] rawVal [3];
  logic signed [15:0] lpState [3];
  logic signed [15:0] refVal [3];
  logic signed [15:0] pathVal [3];
  logic signed [15:0] ofsVal [3];
  logic [SAMPLE_W-1:0] filtVal [3];
  logic filtValid;
  logic refArmed;
  logic [3:0] lpShift;

  assign rawVal[0] = 16'(signed'(sampleX));
  assign rawVal[1] = 16'(signed'(sampleY));
  assign rawVal[2] = 16'(signed'(sampleZ));
  assign lpShift = 4'(filterCtrlReg[BW_LSB+:2]) + 4'h1;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      ofsVal[i] = ofsCtrlReg[OFS_WEIGHT_BIT] ?
        16'(signed'(offsetReg[i])) <<< OFS_SHIFT_HEAVY :
        16'(signed'(offsetReg[i])) <<< OFS_SHIFT_LIGHT;
      if (filterCtrlReg[PATH_SELECT_BIT])
      begin
        if (ofsCtrlReg[HP_REF_BIT])
          pathVal[i] = rawVal[i] - refVal[i];
        else
          pathVal[i] = rawVal[i] - lpState[i];
      end
      else
      begin
        if (filterCtrlReg[BW_LSB+:2] == 2'b00)
          pathVal[i] = rawVal[i];
        else
          pathVal[i] = lpState[i] + ((rawVal[i] - lpState[i]) >>> lpShift);
        if (ofsCtrlReg[OFS_TO_OUT_BIT])
          pathVal[i] = pathVal[i] - ofsVal[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 3; i++)
      begin
        lpState[i] <= 16'sh0000;
        refVal[i] <= 16'sh0000;
        filtVal[i] <= '0;
      end
      filtValid <= 1'b0;
      refArmed <= 1'b0;
    end
    else
    begin
      filtValid <= sampleValid;
      if (sampleValid)
      begin
        refArmed <= ofsCtrlReg[HP_REF_BIT];
        for (int i = 0; i < 3; i++)
        begin
          lpState[i] <= lpState[i] + ((rawVal[i] - lpState[i]) >>> lpShift);
          if (ofsCtrlReg[HP_REF_BIT] && !refArmed)
            refVal[i] <= rawVal[i];
          if (pathVal[i] > 16'sh1FFF)
            filtVal[i] <= 14'h1FFF;
          else if (pathVal[i] < -16'sh2000)
            filtVal[i] <= 14'h2000;
          else
            filtVal[i] <= pathVal[i][SAMPLE_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger and effective mode
  // ----------------------------------------------------------------
  asfp_mode_t modeSel;
  logic trigSeen;
  logic trigNow;
  logic storeOn;
  logic overwriteOn;
  assign modeSel = asfp_mode_t'(bufCtrlReg[MODE_LSB+:3]);
  assign trigNow = |(eventFlags & pin1RouteReg[TRIG_ROUTE_LSB+:EVENT_W]);

  always_ff @(posedge clk)
  begin
    if (reset)
      trigSeen <= 1'b0;
    else if (trigNow)
      trigSeen <= 1'b1;
    else if (bufCtrlWr)
      trigSeen <= 1'b0;
  end

  always_comb
  begin
    case (modeSel)
      ASFP_STOP_FULL: {storeOn, overwriteOn} = 2'b10;
      ASFP_CONT_TO_STOP: {storeOn, overwriteOn} = {1'b1, !trigSeen};
      ASFP_BYPASS_TO_CONT: {storeOn, overwriteOn} = {trigSeen, 1'b1};
      ASFP_CONTINUOUS: {storeOn, overwriteOn} = 2'b11;
      default: {storeOn, overwriteOn} = 2'b00;
    endcase
  end

  // ----------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------
  logic [3*SAMPLE_W-1:0] slotMem [DEPTH];
  logic [4:0] wrPtr;
  logic [4:0] rdPtr;
  logic [5:0] levelReg;
  logic overrunReg;
  logic [3*SAMPLE_W-1:0] curSet;
  logic [3*SAMPLE_W-1:0] oldest;
  logic isFull;
  logic popSet;
  logic pushSet;
  logic overwrite;
  assign isFull = levelReg == FULL_LEVEL;
  assign popSet = accRead && curAddr == ADDR_OUT_LAST && modeSel != ASFP_BYPASS && levelReg != 6'h00;
  assign overwrite = filtValid && storeOn && isFull && !popSet && overwriteOn;
  assign pushSet = filtValid && storeOn && (!isFull || popSet || overwriteOn);
  assign oldest = slotMem[rdPtr];

  always_ff @(posedge clk)
  begin
    if (pushSet)
      slotMem[wrPtr] <= {filtVal[2], filtVal[1], filtVal[0]};
  end

  always_ff @(posedge clk)
  begin
    if (reset || bypassWr)
    begin
      wrPtr <= 5'h00;
      rdPtr <= 5'h00;
      levelReg <= 6'h00;
    end
    else
    begin
      if (pushSet)
        wrPtr <= wrPtr + 5'h01;
      if (popSet || overwrite)
        rdPtr <= rdPtr + 5'h01;
      if (pushSet && !popSet && !overwrite)
        levelReg <= levelReg + 6'h01;
      else if (popSet && !pushSet)
        levelReg <= levelReg - 6'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || bypassWr)
      overrunReg <= 1'b0;
    else if (overwrite)
      overrunReg <= 1'b1;
    else if (popSet)
      overrunReg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      curSet <= '0;
    else if (filtValid)
      curSet <= {filtVal[2], filtVal[1], filtVal[0]};
  end

  // ----------------------------------------------------------------
  // Threshold flag and interrupt pins
  // ----------------------------------------------------------------
  logic threshFlag;

  assign threshFlag = bufCtrlReg[4:0] != 5'h00 && levelReg >= {1'b0, bufCtrlReg[4:0]};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      intPinOne <= 1'b0;
      intPinTwo <= 1'b0;
    end
    else
    begin
      intPinOne <= threshFlag && pin1RouteReg[THRESH_ROUTE_BIT];
      intPinTwo <= threshFlag && pin2RouteReg[THRESH_ROUTE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [3*SAMPLE_W-1:0] shownSet;
  logic [15:0] shownWord;
  logic [7:0] rdMux;
  logic [1:0] axisSel;
  assign shownSet = modeSel == ASFP_BYPASS ? curSet : oldest;
  assign axisSel = 2'((curAddr - ADDR_OUT_FIRST) >> 1);

  always_comb
  begin
    case (axisSel)
      2'h0: shownWord = {shownSet[SAMPLE_W-1:0], 2'b00};
      2'h1: shownWord = {shownSet[2*SAMPLE_W-1:SAMPLE_W], 2'b00};
      default: shownWord = {shownSet[3*SAMPLE_W-1:2*SAMPLE_W], 2'b00};
    endcase
    rdMux = 8'h00;
    if (curAddr >= ADDR_OUT_FIRST && curAddr <= ADDR_OUT_LAST)
      rdMux = curAddr[0] ? shownWord[15:8] : shownWord[7:0];
    else
    begin
      case (curAddr)
        ADDR_RATE_MODE: rdMux = rateModeReg;
        ADDR_IF_CTRL: rdMux = ifCtrlReg;
        ADDR_PIN1_ROUTE: rdMux = pin1RouteReg;
        ADDR_PIN2_ROUTE: rdMux = pin2RouteReg;
        ADDR_FILTER_CTRL: rdMux = filterCtrlReg;
        ADDR_BUF_CTRL: rdMux = bufCtrlReg;
        ADDR_BUF_LEVEL: rdMux = {threshFlag, overrunReg, levelReg};
        ADDR_X_OFFSET: rdMux = offsetReg[0];
        ADDR_Y_OFFSET: rdMux = offsetReg[1];
        ADDR_Z_OFFSET: rdMux = offsetReg[2];
        ADDR_OFS_CTRL: rdMux = ofsCtrlReg;
        default: rdMux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      accRdData <= 8'h00;
      accRdValid <= 1'b0;
    end
    else
    begin
      accRdValid <= accRead;
      if (accRead)
        accRdData <= rdMux;
    end
  end
endmodule
`default_nettype wire

/* File: tb/asfp_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module asfp_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic accStart,
  input wire logic [6:0] accAddr,
  input wire logic accWrite,
  input wire logic [7:0] accWrData,
  input wire logic accRead,
  input wire logic [7:0] accRdData,
  input wire logic accRdValid,
  input wire logic intPinOne,
  input wire logic intPinTwo
);
  import asfp_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [7:0] ctl_reg;
  logic route1_reg;
  logic route2_reg;
  logic statRd;
  assign statRd = accRead && accStart && accAddr == ADDR_BUF_LEVEL;
  // Shadows follow addressed writes only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl_reg <= 8'h00;
      route1_reg <= 1'b0;
      route2_reg <= 1'b0;
    end
    else if (accWrite && accStart)
    begin
      if (accAddr == ADDR_BUF_CTRL)
        ctl_reg <= accWrData;
      if (accAddr == ADDR_PIN1_ROUTE)
        route1_reg <= accWrData[THRESH_ROUTE_BIT];
      if (accAddr == ADDR_PIN2_ROUTE)
        route2_reg <= accWrData[THRESH_ROUTE_BIT];
    end
  end
  // ----
  // Properties
  // ----
  AST_RST_QUIET: assert property ($fell(reset) |-> !accRdValid && !intPinOne && !intPinTwo)
    else $error("outputs active after reset");
  AST_RD_ANSWER: assert property (accRead |=> accRdValid)
    else $error("read not answered");
  AST_RD_CAUSE: assert property (accRdValid |-> $past(accRead))
    else $error("answer without read");
  AST_RD_HOLD: assert property (!accRdValid |-> $stable(accRdData))
    else $error("read data moved");
  AST_LEVEL_MAX: assert property (statRd |=> accRdData[5:0] <= FULL_LEVEL)
    else $error("level above full");
  AST_OVR_FULL: assert property (statRd ##1 accRdData[FLAG_OVR_BIT] |-> accRdData[5:0] == FULL_LEVEL)
    else $error("overrun without full buffer");
  AST_BYPASS_EMPTY: assert property (statRd && ctl_reg[7:5] == 3'h0 && $past(ctl_reg[7:5]) == 3'h0
    |=> accRdData[6:0] == 7'h00)
    else $error("bypass buffer not empty");
  AST_INTERRUPT_PIN_ONE_ROUTE: assert property (intPinOne |-> route1_reg || $past(route1_reg))
    else $error("pin one without route");
  AST_INTERRUPT_PIN_TWO_ROUTE: assert property (intPinTwo |-> route2_reg || $past(route2_reg))
    else $error("pin two without route");
  AST_THR_ZERO: assert property ((intPinOne || intPinTwo) |-> ctl_reg[4:0] != 5'h00
    || $past(ctl_reg[4:0]) != 5'h00 || $past(ctl_reg[4:0], 2) != 5'h00)
    else $error("pin high with zero threshold");
  COV_THR: cover property (statRd ##1 accRdData[FLAG_THRESH_BIT]);
  COV_OVR: cover property (statRd ##1 accRdData[FLAG_OVR_BIT]);
  COV_PIN: cover property (intPinOne && intPinTwo);
endmodule
`default_nettype wire

/* File: tb/asfp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module asfp_host
(
  input wire logic clk,
  output logic accStart,
  output logic [6:0] accAddr,
  output logic accWrite,
  output logic [7:0] accWrData,
  output logic accRead,
  input wire logic [7:0] accRdData,
  input wire logic accRdValid
);
  initial
  begin
    accStart = 1'b0;
    accAddr = 7'h00;
    accWrite = 1'b0;
    accWrData = 8'h00;
    accRead = 1'b0;
  end
  // Released address and data lines show the inverse of the last value; strobes drop to 0
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    accStart <= 1'b1;
    accAddr <= a;
    accWrite <= 1'b1;
    accWrData <= d;
    @(posedge clk);
    accStart <= 1'b0;
    accAddr <= ~a;
    accWrite <= 1'b0;
    accWrData <= ~d;
  endtask
  task automatic rd(input logic s, input logic [6:0] a, input int n, output logic [7:0] q [$]);
    q = {};
    @(posedge clk);
    accStart <= s;
    accAddr <= a;
    accRead <= 1'b1;
    for (int i = 1; i <= n + 1; i++)
    begin
      @(posedge clk);
      accStart <= 1'b0;
      accAddr <= ~a;
      if (i == n)
        accRead <= 1'b0;
      if (i >= 2)
        q.push_back(accRdValid === 1'b1 ? accRdData : 8'hXX);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import asfp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sampleValid = 1'b0;
  logic [SAMPLE_W-1:0] sampleX = 14'h0000;
  logic [SAMPLE_W-1:0] sampleY = 14'h0000;
  logic [SAMPLE_W-1:0] sampleZ = 14'h0000;
  logic [EVENT_W-1:0] eventFlags = 5'h00;
  wire logic accStart;
  wire logic [6:0] accAddr;
  wire logic accWrite;
  wire logic [7:0] accWrData;
  wire logic accRead;
  wire logic [7:0] accRdData;
  wire logic accRdValid;
  wire logic intPinOne;
  wire logic intPinTwo;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] q [$];
  always #5 clk = ~clk;
  asfp_core uut (.clk, .reset, .accStart, .accAddr, .accWrite, .accWrData, .accRead, .accRdData,
    .accRdValid, .sampleValid, .sampleX, .sampleY, .sampleZ, .eventFlags, .intPinOne, .intPinTwo);
  asfp_host host (.clk, .accStart, .accAddr, .accWrite, .accWrData, .accRead, .accRdData, .accRdValid);
  // ----
  // Helpers
  // ----
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic push(input int k);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleX <= 14'(k);
    sampleY <= 14'(k) + 14'h0100;
    sampleZ <= 14'(k) + 14'h2000;
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic trig(input logic [4:0] f);
    @(posedge clk);
    eventFlags <= f;
    @(posedge clk);
    eventFlags <= 5'h00;
  endtask
  task automatic stat(input logic [7:0] e);
    host.rd(1'b1, ADDR_BUF_LEVEL, 1, q);
    chk8("status", e, q[0]);
  endtask
  // Two X output bytes, left-justified
  task automatic chkX(input logic [13:0] e);
    host.rd(1'b1, ADDR_OUT_FIRST, 2, q);
    chk8("x low", {e[5:0], 2'b00}, q[0]);
    chk8("x high", e[13:6], q[1]);
  endtask
  // Six output bytes, left-justified
  task automatic chkSet(input int k, input int b);
    logic [13:0] v [3];
    v = '{14'(k), 14'(k) + 14'h0100, 14'(k) + 14'h2000};
    for (int i = 0; i < 3; i++)
    begin
      chk8("low byte", {v[i][5:0], 2'b00}, q[b + 2 * i]);
      chk8("high byte", v[i][13:6], q[b + 2 * i + 1]);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    host.rd(1'b1, ADDR_IF_CTRL, 1, q);
    chk8("if ctrl", IF_CTRL_RESET, q[0]);
    host.rd(1'b1, 7'h22, 1, q);
    chk8("unmapped", 8'h00, q[0]);
    host.wr(ADDR_X_OFFSET, 8'h5A);
    host.rd(1'b1, ADDR_X_OFFSET, 1, q);
    chk8("x offset", 8'h5A, q[0]);
    host.wr(ADDR_BUF_LEVEL, 8'hFF);
    stat(8'h00);
    $display("regs done");
  endtask
  task automatic t_fifo;
    host.wr(ADDR_PIN1_ROUTE, 8'h02);
    host.wr(ADDR_PIN2_ROUTE, 8'h02);
    host.wr(ADDR_BUF_CTRL, 8'h24);
    push(99);
    host.rd(1'b1, ADDR_OUT_FIRST, 6, q);
    for (int k = 0; k < 3; k++)
      push(k);
    stat(8'h03);
    chk1("pin one", 1'b0, intPinOne);
    push(3);
    stat(8'h84);
    chk1("pin one", 1'b1, intPinOne);
    chk1("pin two", 1'b1, intPinTwo);
    for (int k = 4; k < 34; k++)
      push(k);
    stat(8'hA0);
    host.rd(1'b1, ADDR_OUT_FIRST, 12, q);
    chkSet(0, 0);
    chkSet(1, 6);
    stat(8'h9E);
    for (int k = 2; k < 32; k++)
    begin
      host.rd(1'b1, ADDR_OUT_FIRST, 6, q);
      chkSet(k, 0);
    end
    stat(8'h00);
    $display("fifo mode done");
  endtask
  task automatic t_cont;
    host.wr(ADDR_BUF_CTRL, 8'h00);
    host.wr(ADDR_BUF_CTRL, 8'hC0);
    for (int k = 0; k < 33; k++)
      push(k);
    stat(8'h60);
    chk1("pin one", 1'b0, intPinOne);
    host.rd(1'b1, ADDR_OUT_FIRST, 6, q);
    chkSet(1, 0);
    $display("continuous done");
  endtask
  task automatic t_c2f;
    host.wr(ADDR_BUF_CTRL, 8'h00);
    stat(8'h00);
    host.wr(ADDR_PIN1_ROUTE, 8'h0A);
    host.wr(ADDR_BUF_CTRL, 8'h60);
    for (int k = 0; k < 33; k++)
      push(k);
    trig(5'h01);
    push(33);
    stat(8'h60);
    host.rd(1'b1, ADDR_OUT_FIRST, 6, q);
    chkSet(1, 0);
    $display("continuous to fifo done");
  endtask
  task automatic t_trig;
    host.wr(ADDR_BUF_CTRL, 8'h00);
    for (int k = 7; k < 9; k++)
    begin
      push(k);
      host.rd(1'b1, ADDR_OUT_FIRST, 6, q);
      chkSet(k, 0);
    end
    stat(8'h00);
    host.wr(ADDR_BUF_CTRL, 8'h80);
    trig(5'h02);
    push(20);
    stat(8'h00);
    trig(5'h01);
    push(21);
    stat(8'h01);
    host.rd(1'b1, ADDR_OUT_FIRST, 6, q);
    chkSet(21, 0);
    $display("bypass to continuous done");
  endtask
  task automatic t_filt;
    host.wr(ADDR_BUF_CTRL, 8'h00);
    host.wr(ADDR_RATE_MODE, 8'h10);
    push(0);
    host.wr(ADDR_OFS_CTRL, 8'h10);
    push(1024);
    chkX(14'h0400 - (14'h005A << OFS_SHIFT_LIGHT));
    host.wr(ADDR_OFS_CTRL, 8'h14);
    push(1024);
    chkX(14'h0400 - (14'h005A << OFS_SHIFT_HEAVY));
    host.wr(ADDR_OFS_CTRL, 8'h02);
    host.wr(ADDR_FILTER_CTRL, 8'h08);
    push(100);
    push(105);
    chkX(14'h0005);
    $display("filter path done");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[ERR] run length expected under 20000 seen %0d", cyc);
      test_done();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_fifo();
    t_cont();
    t_c2f();
    t_trig();
    t_filt();
    test_done();
  end
endmodule
bind asfp_core asfp_checker chk (.clk, .reset, .accStart, .accAddr, .accWrite, .accWrData, .accRead,
  .accRdData, .accRdValid, .intPinOne, .intPinTwo);
`default_nettype wire
